// ==== verilog/adc_cal_pkg.sv ====
// shared constants and state types for the converter calibration ends
// assumes one 25 MHz reference clock shared by both ends
package adc_cal_pkg;

  // reference clock
  localparam int CLK_PERIOD_NS = 40;

  // calibration time, nominal and longest, in milliseconds
  localparam int CAL_NOM_MS = 200;
  localparam int CAL_MAX_MS = 550;
  localparam int NS_PER_MS = 1000000;
  // nominal and longest both divide exactly
  localparam int CAL_NOM_CYCLES = (CAL_NOM_MS * NS_PER_MS) / CLK_PERIOD_NS;
  localparam int CAL_MAX_CYCLES = (CAL_MAX_MS * NS_PER_MS) / CLK_PERIOD_NS;
  localparam int CAL_CNT_W = 24;

  // least low time of a recalibration request, in reference cycles
  localparam int RECAL_LOW_MIN_CYCLES = 1;
  localparam int PULL_CNT_W = 8;

  // one conversion period is two reference cycles, so eight and one half
  // conversion periods of latency are seventeen reference edges
  localparam int CONV_HALF_STEPS = 2;
  localparam int LATENCY_HALF_STEPS = 17;

  // sample format: offset binary code plus over-range bit
  localparam int CODE_W = 12;
  localparam logic [CODE_W:0] FULL_SCALE = 13'h0FFF;
  localparam logic [CODE_W-1:0] CODE_MAX = 12'hFFF;

  // reset values
  localparam logic POR_DRIVE_RST = 1'b1;
  localparam logic CFG_SELECT_N_RST = 1'b1;

  typedef enum logic [3:0] {
    DEV_HOLD = 4'h1,
    DEV_LOW = 4'h2,
    DEV_CAL = 4'h4,
    DEV_RUN = 4'h8
  } dev_state_type;

  typedef enum logic [3:0] {
    HOST_BOOT = 4'h1,
    HOST_WAIT = 4'h2,
    HOST_READY = 4'h4,
    HOST_PULL = 4'h8
  } host_state_type;

endpackage

// ==== verilog/adc_cal_link_if.sv ====
// link between the converter end and the host end
// resolves the open-drain recalibration line and the pulled-up readback line
`timescale 1ns/10ps
`default_nettype none
interface adc_cal_link_if;
  // open-drain recalibration line with pull-up
  logic recal_host_oe;
  logic recal_dev_oe;
  logic recal_trigger_n;
  // pulled-up readback line, host may only pull it low
  logic serial_readback_host_oe;
  logic serial_readback_line;
  // reserved pins, must stay undriven
  logic reserved_pins_oe;
  logic reserved_pins;
  // host side conditions
  logic clock_stable;
  logic cfg_select_n;
  // converter outputs
  logic over_range_flag_true;
  logic over_range_flag_comp;
  logic output_sample_clock_true;
  logic output_sample_clock_comp;
  logic [adc_cal_pkg::CODE_W-1:0] sample_data;

  // low when either party drives, high through the pull-up otherwise
  assign recal_trigger_n = ~(recal_host_oe | recal_dev_oe);
  assign serial_readback_line = ~serial_readback_host_oe;
  assign reserved_pins = reserved_pins_oe;

  modport dev (
    output recal_dev_oe,
    output over_range_flag_true,
    output over_range_flag_comp,
    output output_sample_clock_true,
    output output_sample_clock_comp,
    output sample_data,
    input recal_trigger_n,
    input serial_readback_line,
    input reserved_pins,
    input clock_stable,
    input cfg_select_n
  );

  modport host (
    output recal_host_oe,
    output serial_readback_host_oe,
    output reserved_pins_oe,
    output clock_stable,
    output cfg_select_n,
    input recal_trigger_n,
    input over_range_flag_true
  );
endinterface
`default_nettype wire

// ==== verilog/adc_cal_dev.sv ====
// converter end: supply-monitor reset, calibration sequencing, output
// pipeline, over-range flag and output sample clock
// assumes the link pins and the supply monitor arrive asynchronously and
// the analog level comes from logic on the same clock
//
// Notes on behaviour
// - sample leaves after eight and half periods
// - supply monitor starts calibration at power-up
// - monitor releases line, pull-up raises it
// - host keeps conversion clock stable during calibration
// - host never pulls readback line low
// - recalibration line starts low at power-up
// - no configuration transfer during calibration
// - calibration starts on recalibration line rising edge
// - over-range high from line low to done
// - over-range input keeps flag high after done
// - sample clock low while line low
// - sample clock resumes third edge after release, after two sync stages
// - calibration nominal 200ms, at most 550ms
// - host pulls line low one cycle minimum
// - host keeps pins in calibration states
// - host recalibrates at highest sample rate
// - over-range at full scale, no wrap
`timescale 1ns/10ps
`default_nettype none
module adc_cal_dev #(
  parameter int CAL_CYCLES = adc_cal_pkg::CAL_NOM_CYCLES,
  parameter int LAT_STEPS = adc_cal_pkg::LATENCY_HALF_STEPS
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // supply monitor and analog level
  input wire logic i_supply_good,
  input wire logic [adc_cal_pkg::CODE_W:0] i_analog_level,
  // status
  output logic o_cal_busy,
  output logic o_cal_done,
  output logic o_cal_fault,
  // link
  adc_cal_link_if.dev link
);

  localparam int SW = adc_cal_pkg::CODE_W + 1;
  localparam logic [adc_cal_pkg::CAL_CNT_W-1:0] CAL_LAST =
    adc_cal_pkg::CAL_CNT_W'(CAL_CYCLES - 1);

  typedef struct packed {
    adc_cal_pkg::dev_state_type state;
    logic [1:0] line_sync;
    logic [1:0] sdo_sync;
    logic [1:0] rsv_sync;
    logic [1:0] clk_ok_sync;
    logic [1:0] cs_sync;
    logic [1:0] supply_sync;
    logic line_prev;
    logic [adc_cal_pkg::CAL_CNT_W-1:0] cal_cnt;
    logic [LAT_STEPS-1:0][SW-1:0] pipe;
    logic por_drive;
    logic or_true;
    logic or_comp;
    logic sclk_true;
    logic sclk_comp;
    logic [adc_cal_pkg::CODE_W-1:0] data;
    logic busy;
    logic done;
    logic fault;
  } dev_regs_type;

  dev_regs_type r;
  dev_regs_type next_r;
  logic [SW-1:0] conv_word;
  logic line_level;
  logic line_rise;
  logic bad_cond;
  logic supply_good;

  // clamp at full scale so the code never wraps
  always_comb
  begin
    if (i_analog_level >= adc_cal_pkg::FULL_SCALE)
    begin
      conv_word = {1'b1, adc_cal_pkg::CODE_MAX};
    end
    else
    begin
      conv_word = {1'b0, i_analog_level[adc_cal_pkg::CODE_W-1:0]};
    end
  end

  // only second sync stages are looked at
  assign line_level = r.line_sync[1];
  assign line_rise = r.line_sync[1] & ~r.line_prev;
  // the supply monitor is analog, so it is synchronised like a pin
  assign supply_good = r.supply_sync[1];
  // conditions the host must hold while calibrating
  assign bad_cond = ~r.sdo_sync[1] | r.rsv_sync[1] | ~r.clk_ok_sync[1] | ~r.cs_sync[1];

  // next-state logic for the whole converter end
  always_comb
  begin
    next_r = r;
    next_r.line_sync = {r.line_sync[0], link.recal_trigger_n};
    next_r.sdo_sync = {r.sdo_sync[0], link.serial_readback_line};
    next_r.rsv_sync = {r.rsv_sync[0], link.reserved_pins};
    next_r.clk_ok_sync = {r.clk_ok_sync[0], link.clock_stable};
    next_r.cs_sync = {r.cs_sync[0], link.cfg_select_n};
    next_r.supply_sync = {r.supply_sync[0], i_supply_good};
    next_r.line_prev = r.line_sync[1];
    next_r.done = 1'b0;

    // conversion pipeline; a sample captured on one edge leaves LAT_STEPS edges later
    next_r.pipe = {r.pipe[LAT_STEPS-2:0], conv_word};
    next_r.data = r.pipe[LAT_STEPS-1][adc_cal_pkg::CODE_W-1:0];

    case (r.state)
      adc_cal_pkg::DEV_HOLD:
      begin
        // supply monitor holds the line low until both supplies are up
        next_r.por_drive = 1'b1;
        if (supply_good)
        begin
          next_r.por_drive = 1'b0;
          next_r.state = adc_cal_pkg::DEV_LOW;
        end
      end
      adc_cal_pkg::DEV_LOW:
      begin
        if (line_rise)
        begin
          next_r.state = adc_cal_pkg::DEV_CAL;
          next_r.cal_cnt = '0;
          next_r.fault = 1'b0;
          next_r.busy = 1'b1;
        end
      end
      adc_cal_pkg::DEV_CAL:
      begin
        if (bad_cond)
        begin
          // sticky until the next calibration starts
          next_r.fault = 1'b1;
        end
        if (!line_level)
        begin
          next_r.state = adc_cal_pkg::DEV_LOW;
        end
        else if (r.cal_cnt == CAL_LAST)
        begin
          next_r.state = adc_cal_pkg::DEV_RUN;
          next_r.busy = 1'b0;
          next_r.done = 1'b1;
        end
        else
        begin
          next_r.cal_cnt = r.cal_cnt + 1'b1;
        end
      end
      adc_cal_pkg::DEV_RUN:
      begin
        if (!line_level)
        begin
          next_r.state = adc_cal_pkg::DEV_LOW;
        end
      end
      default:
      begin
        next_r.state = adc_cal_pkg::DEV_HOLD;
      end
    endcase

    // a supply drop anywhere restarts the power-up sequence
    if (!supply_good)
    begin
      next_r.state = adc_cal_pkg::DEV_HOLD;
      next_r.por_drive = 1'b1;
      next_r.busy = 1'b0;
    end
    // the host pulling the line low aborts and re-arms a calibration
    if (!line_level && r.state != adc_cal_pkg::DEV_HOLD)
    begin
      next_r.busy = 1'b0;
    end

    // sample clock held low while the line is low or the next state is hold or low, toggles otherwise
    if (!line_level || next_r.state == adc_cal_pkg::DEV_HOLD
        || next_r.state == adc_cal_pkg::DEV_LOW)
    begin
      next_r.sclk_true = 1'b0;
    end
    else
    begin
      next_r.sclk_true = ~r.sclk_true;
    end
    next_r.sclk_comp = ~next_r.sclk_true;

    // flag forced high from line low until calibration completes
    if (next_r.state == adc_cal_pkg::DEV_RUN)
    begin
      // stays high when the input is over range at the end
      next_r.or_true = r.pipe[LAT_STEPS-1][SW-1];
    end
    else
    begin
      next_r.or_true = 1'b1;
    end
    next_r.or_comp = ~next_r.or_true;
  end

  // one register for all state; constant reset only
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      r <= '0;
      r.state <= adc_cal_pkg::DEV_HOLD;
      r.por_drive <= adc_cal_pkg::POR_DRIVE_RST;
      r.or_true <= 1'b1;
      r.sclk_comp <= 1'b1;
      r.line_sync <= 2'h0;
      r.sdo_sync <= 2'h3;
      r.clk_ok_sync <= 2'h3;
      r.cs_sync <= 2'h3;
    end
    else
    begin
      r <= next_r;
    end
  end

  // outputs straight from the register
  assign link.recal_dev_oe = r.por_drive;
  assign link.over_range_flag_true = r.or_true;
  assign link.over_range_flag_comp = r.or_comp;
  assign link.output_sample_clock_true = r.sclk_true;
  assign link.output_sample_clock_comp = r.sclk_comp;
  assign link.sample_data = r.data;
  assign o_cal_busy = r.busy;
  assign o_cal_done = r.done;
  assign o_cal_fault = r.fault;

endmodule
`default_nettype wire

// ==== verilog/adc_cal_host.sv ====
// host end: keeps the calibration preconditions, requests recalibration
// and decides when converted data may be trusted
// assumes the link pins arrive asynchronously, user inputs are synchronous
`timescale 1ns/10ps
`default_nettype none
module adc_cal_host #(
  parameter int WAIT_CYCLES = adc_cal_pkg::CAL_MAX_CYCLES,
  parameter int LOW_CYCLES = adc_cal_pkg::RECAL_LOW_MIN_CYCLES
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // user requests
  input wire logic i_recal_request,
  input wire logic i_at_max_rate,
  input wire logic i_cfg_select_n,
  // user status
  output logic o_ready,
  output logic o_cal_done,
  output logic o_cal_timeout,
  output logic o_refused,
  // link
  adc_cal_link_if.host link
);

  localparam logic [adc_cal_pkg::CAL_CNT_W-1:0] WAIT_LAST =
    adc_cal_pkg::CAL_CNT_W'(WAIT_CYCLES - 1);
  localparam logic [adc_cal_pkg::PULL_CNT_W-1:0] LOW_LAST =
    adc_cal_pkg::PULL_CNT_W'(LOW_CYCLES - 1);

  typedef struct packed {
    adc_cal_pkg::host_state_type state;
    logic [1:0] line_sync;
    logic [1:0] or_sync;
    logic seen_high;
    logic [adc_cal_pkg::CAL_CNT_W-1:0] wait_cnt;
    logic [adc_cal_pkg::PULL_CNT_W-1:0] pull_cnt;
    logic drive_low;
    logic cs_n;
    logic ready;
    logic done;
    logic timeout;
    logic refused;
  } host_regs_type;

  host_regs_type r;
  host_regs_type next_r;

  // next-state logic for the host end
  always_comb
  begin
    next_r = r;
    next_r.line_sync = {r.line_sync[0], link.recal_trigger_n};
    next_r.or_sync = {r.or_sync[0], link.over_range_flag_true};
    next_r.done = 1'b0;
    next_r.timeout = 1'b0;
    next_r.refused = 1'b0;
    case (r.state)
      adc_cal_pkg::HOST_BOOT:
      begin
        // line released high means calibration has begun
        next_r.cs_n = 1'b1;
        if (r.line_sync[1])
        begin
          next_r.state = adc_cal_pkg::HOST_WAIT;
          next_r.wait_cnt = '0;
          next_r.seen_high = 1'b0;
        end
      end
      adc_cal_pkg::HOST_WAIT:
      begin
        next_r.cs_n = 1'b1;
        if (r.or_sync[1])
        begin
          next_r.seen_high = 1'b1;
        end
        if (!r.line_sync[1])
        begin
          next_r.state = adc_cal_pkg::HOST_BOOT;
        end
        else if (r.seen_high && !r.or_sync[1])
        begin
          next_r.state = adc_cal_pkg::HOST_READY;
          next_r.ready = 1'b1;
          next_r.done = 1'b1;
        end
        else if (r.wait_cnt == WAIT_LAST)
        begin
          // flag may stay high on an over-range input, so time out
          next_r.state = adc_cal_pkg::HOST_READY;
          next_r.ready = 1'b1;
          next_r.timeout = 1'b1;
        end
        else
        begin
          next_r.wait_cnt = r.wait_cnt + 1'b1;
        end
      end
      adc_cal_pkg::HOST_READY:
      begin
        next_r.cs_n = i_cfg_select_n;
        if (!r.line_sync[1])
        begin
          // converter restarted by itself
          next_r.state = adc_cal_pkg::HOST_BOOT;
          next_r.ready = 1'b0;
          next_r.cs_n = 1'b1;
        end
        else if (i_recal_request && i_at_max_rate)
        begin
          next_r.state = adc_cal_pkg::HOST_PULL;
          next_r.drive_low = 1'b1;
          next_r.pull_cnt = '0;
          next_r.ready = 1'b0;
          next_r.cs_n = 1'b1;
        end
        else if (i_recal_request)
        begin
          next_r.refused = 1'b1;
        end
      end
      adc_cal_pkg::HOST_PULL:
      begin
        // hold low for the least time and until the line is seen low
        next_r.cs_n = 1'b1;
        if (r.pull_cnt != LOW_LAST)
        begin
          next_r.pull_cnt = r.pull_cnt + 1'b1;
        end
        else if (!r.line_sync[1])
        begin
          next_r.drive_low = 1'b0;
          next_r.state = adc_cal_pkg::HOST_BOOT;
        end
      end
      default:
      begin
        next_r.state = adc_cal_pkg::HOST_BOOT;
      end
    endcase
  end

  // one register for all state; constant reset only
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      r <= '0;
      r.state <= adc_cal_pkg::HOST_BOOT;
      r.cs_n <= adc_cal_pkg::CFG_SELECT_N_RST;
    end
    else
    begin
      r <= next_r;
    end
  end

  // readback and reserved pins never driven, clock always stable
  assign link.recal_host_oe = r.drive_low;
  assign link.serial_readback_host_oe = 1'b0;
  assign link.reserved_pins_oe = 1'b0;
  assign link.clock_stable = 1'b1;
  assign link.cfg_select_n = r.cs_n;
  assign o_ready = r.ready;
  assign o_cal_done = r.done;
  assign o_cal_timeout = r.timeout;
  assign o_refused = r.refused;

endmodule
`default_nettype wire

// ==== testbench/adc_cal_sva.sv ====
// concurrent checks on the link between the converter end and the host end
// assumes one reference clock and a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module adc_cal_sva (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // link signals
  input wire logic recal_trigger_n,
  input wire logic recal_host_oe,
  input wire logic serial_readback_line,
  input wire logic reserved_pins,
  input wire logic over_range_flag_true,
  input wire logic over_range_flag_comp,
  input wire logic output_sample_clock_true,
  input wire logic output_sample_clock_comp,
  input wire logic [adc_cal_pkg::CODE_W-1:0] sample_data
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  // flag and clock pins behave as true/complement pairs
  a_flag_pair_inverse: assert property (over_range_flag_comp == !over_range_flag_true)
    else $error("flag complement wrong");
  a_sclk_pair_inverse: assert property (output_sample_clock_comp ==
    !output_sample_clock_true)
    else $error("sample clock complement wrong");
  // line falling forces the flag up and the sample clock down, sync delay allowed
  a_flag_up_low: assert property ($fell(recal_trigger_n) |-> ##[1:6] over_range_flag_true)
    else $error("flag not raised after line low");
  a_sclk_low_line: assert property ($fell(recal_trigger_n) |->
    ##[1:6] !output_sample_clock_true)
    else $error("sample clock not held low");
  a_flag_held_cal: assert property ($rose(recal_trigger_n) ##1 recal_trigger_n[*8] |->
    over_range_flag_true)
    else $error("flag dropped early in calibration");
  // once the line is settled high the sample clock toggles on every edge
  a_sclk_keeps_toggling: assert property (recal_trigger_n[*6] |->
    output_sample_clock_true != $past(output_sample_clock_true))
    else $error("sample clock not toggling");
  // a clamped code shows as full scale and always carries the flag
  a_code_no_wrap: assert property (!over_range_flag_true |->
    sample_data != adc_cal_pkg::CODE_MAX)
    else $error("full scale code without flag");
  a_host_pull_span: assert property ($rose(recal_host_oe) |=>
    recal_host_oe ##[1:6] !recal_host_oe)
    else $error("host pull too short or stuck");
  a_readback_high: assert property (serial_readback_line)
    else $error("readback line pulled low");
  a_reserved_free: assert property (!reserved_pins)
    else $error("reserved pins driven");

  cover property ($rose(recal_host_oe));
  cover property ($rose(recal_trigger_n));
  cover property ($fell(over_range_flag_true));
endmodule
`default_nettype wire

// ==== testbench/adc_calibration_reset_sequencer_tb_top.sv ====
// self-checking bench: converter end and host end joined by the link
// assumes both ends share one 25 MHz clock; counts are shortened by parameter
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
  $display("BAD %0t got %0h exp %0h", $time, a, b); end end
module adc_calibration_reset_sequencer_tb_top;
  typedef struct packed {logic [12:0] lvl; logic [11:0] data; logic flag;} row_type;
  localparam int CAL = 50;
  localparam int WAIT = 200;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic supply_good = 1'b0;
  logic [adc_cal_pkg::CODE_W:0] level = 13'h0100;
  logic recal_request = 1'b0;
  logic at_max_rate = 1'b1;
  logic cfg_select_n = 1'b1;
  logic cal_busy, cal_done, cal_fault, ready, host_done, host_timeout, refused;
  logic [11:0] prev;
  int failures = 0;
  int checked = 0;
  int n;
  // in-range codes pass straight through; anything at or past full scale clamps
  row_type rows [6] = '{'{13'h0000, 12'h000, 1'b0}, '{13'h0800, 12'h800, 1'b0},
    '{13'h0FFE, 12'hFFE, 1'b0}, '{13'h0FFF, 12'hFFF, 1'b1},
    '{13'h1800, 12'hFFF, 1'b1}, '{13'h0001, 12'h001, 1'b0}};

  // 40 ns reference clock
  always #20 i_ref_clk = ~i_ref_clk;

  adc_cal_link_if u_adc_cal_link_if ();
  adc_cal_dev #(.CAL_CYCLES(CAL), .LAT_STEPS(adc_cal_pkg::LATENCY_HALF_STEPS)) u_adc_cal_dev (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_supply_good(supply_good),
    .i_analog_level(level), .o_cal_busy(cal_busy), .o_cal_done(cal_done),
    .o_cal_fault(cal_fault), .link(u_adc_cal_link_if.dev));
  adc_cal_host #(.WAIT_CYCLES(WAIT), .LOW_CYCLES(1)) u_adc_cal_host (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_recal_request(recal_request),
    .i_at_max_rate(at_max_rate), .i_cfg_select_n(cfg_select_n), .o_ready(ready),
    .o_cal_done(host_done), .o_cal_timeout(host_timeout), .o_refused(refused),
    .link(u_adc_cal_link_if.host));
  adc_cal_sva u_adc_cal_sva (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .recal_trigger_n(u_adc_cal_link_if.recal_trigger_n),
    .recal_host_oe(u_adc_cal_link_if.recal_host_oe),
    .serial_readback_line(u_adc_cal_link_if.serial_readback_line),
    .reserved_pins(u_adc_cal_link_if.reserved_pins),
    .over_range_flag_true(u_adc_cal_link_if.over_range_flag_true),
    .over_range_flag_comp(u_adc_cal_link_if.over_range_flag_comp),
    .output_sample_clock_true(u_adc_cal_link_if.output_sample_clock_true),
    .output_sample_clock_comp(u_adc_cal_link_if.output_sample_clock_comp),
    .sample_data(u_adc_cal_link_if.sample_data));

  // verdict and end of run, shared by the main sequence and the watchdog
  task automatic end_sim();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // waits on a pulse or level under a bound; pulses last one cycle, so poll each cycle
  task automatic wait_for(input int sel, input int lim, output int cnt);
    logic hit;
    cnt = 0;
    hit = 1'b0;
    while (!hit && cnt < lim)
    begin
      @(negedge i_ref_clk);
      cnt++;
      case (sel)
        0: hit = (cal_done === 1'b1);
        1: hit = (host_done === 1'b1);
        2: hit = (host_timeout === 1'b1);
        3: hit = (cal_busy === 1'b1);
        default: hit = (refused === 1'b1);
      endcase
    end
    if (!hit)
    begin
      failures++;
      $display("BAD %0t wait %0h limit %0h", $time, sel, lim);
    end
  endtask

  // one-cycle user request to the host end
  task automatic request();
    @(negedge i_ref_clk);
    recal_request = 1'b1;
    @(negedge i_ref_clk);
    recal_request = 1'b0;
  endtask

  // main sequence
  initial
  begin
    repeat (3) @(negedge i_ref_clk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_ref_clk);
    `CHK(u_adc_cal_link_if.recal_trigger_n, 1'b0);
    `CHK(u_adc_cal_link_if.over_range_flag_true, 1'b1);
    `CHK(u_adc_cal_link_if.output_sample_clock_true, 1'b0);
    `CHK(cal_busy, 1'b0);
    `CHK(ready, 1'b0);
    supply_good = 1'b1;
    wait_for(3, 8, n);
    `CHK(u_adc_cal_link_if.recal_trigger_n, 1'b1);
    wait_for(0, CAL + 2, n);
    `CHK(n, CAL);
    wait_for(1, 40, n);
    `CHK(ready, 1'b1);
    `CHK(u_adc_cal_link_if.over_range_flag_true, 1'b0);
    // data path latency and clamping, old value one edge before the new
    prev = 12'h100;
    foreach (rows[i])
    begin
      level = rows[i].lvl;
      repeat (17) @(negedge i_ref_clk);
      `CHK(u_adc_cal_link_if.sample_data, prev);
      @(negedge i_ref_clk);
      `CHK(u_adc_cal_link_if.sample_data, rows[i].data);
      `CHK(u_adc_cal_link_if.over_range_flag_true, rows[i].flag);
      prev = rows[i].data;
    end
    level = 13'h0100;
    // request below the top rate is refused and leaves the line alone
    // refusal is a one-cycle pulse, so the request is held while polling for it
    at_max_rate = 1'b0;
    @(negedge i_ref_clk);
    recal_request = 1'b1;
    wait_for(4, 4, n);
    recal_request = 1'b0;
    `CHK(u_adc_cal_link_if.recal_trigger_n, 1'b1);
    `CHK(ready, 1'b1);
    at_max_rate = 1'b1;
    // user recalibration with select held active: must not reach the link during calibration
    cfg_select_n = 1'b0;
    request();
    wait_for(3, 14, n);
    `CHK(ready, 1'b0);
    `CHK(u_adc_cal_link_if.cfg_select_n, 1'b1);
    `CHK(u_adc_cal_link_if.over_range_flag_true, 1'b1);
    wait_for(0, CAL + 2, n);
    `CHK(n, CAL);
    `CHK(cal_fault, 1'b0);
    wait_for(1, 40, n);
    cfg_select_n = 1'b1;
    // over range at the end hides completion; host must fall back on its timeout
    level = 13'h1FFF;
    request();
    wait_for(0, CAL + 14, n);
    repeat (4) @(negedge i_ref_clk);
    `CHK(u_adc_cal_link_if.over_range_flag_true, 1'b1);
    wait_for(2, WAIT + 20, n);
    `CHK(ready, 1'b1);
    level = 13'h0100;
    // second reset in mid calibration restarts from the supply monitor
    request();
    wait_for(3, 14, n);
    i_rst = 1'b1;
    repeat (3) @(negedge i_ref_clk);
    `CHK(cal_busy, 1'b0);
    `CHK(u_adc_cal_link_if.recal_trigger_n, 1'b0);
    i_rst = 1'b0;
    wait_for(0, CAL + 14, n);
    wait_for(1, 40, n);
    end_sim();
  end

  // watchdog well beyond the roughly 520 cycles the sequence needs
  initial
  begin
    repeat (4000) @(posedge i_ref_clk);
    failures++;
    end_sim();
  end
endmodule
`default_nettype wire
